// [flow_totalizer_batch_tb.sv]
/*
  Self-checking bench for the flow totalizer.
  Assumes checker and host model are compiled first.
*/
`timescale 1ns/10ps
module flow_totalizer_batch_tb;
  logic              clk = 1'b0;
  logic              rstn = 1'b0;
  logic              clearKeyPin = 1'b0;
  logic              sampleValid = 1'b0;
  logic              sendClear = 1'b0;
  logic [31:0]       flowSample = 32'h0;
  ftb_pkg::ftb_bus_t bus = '0;
  logic              serClearCmd, nvBatchValid, nvWriteStrobe, valveEnable;
  logic [26:0]       nvBatchValue, nvWriteValue;
  logic [31:0]       rdData;
  int                miscompares = 0;
  int                checksDone = 0;

  always #2 clk = ~clk;

  ftb_flow_totalizer #(.SAMPLE_W(32), .TICKS_SEC(10)) u_dut (
    .clk(clk), .rstn(rstn), .clearKeyPin(clearKeyPin),
    .sampleValid(sampleValid), .flowSample(flowSample),
    .serClearCmd(serClearCmd), .bus(bus), .nvBatchValid(nvBatchValid),
    .nvBatchValue(nvBatchValue), .rdData(rdData), .valveEnable(valveEnable),
    .overflowFlag(), .batchDone(), .totalOut(), .remainOut(),
    .elapsedOut(), .nvWriteStrobe(nvWriteStrobe),
    .nvWriteValue(nvWriteValue));

  ftb_host_model u_host (
    .clk(clk), .rstn(rstn), .sendClear(sendClear),
    .nvWriteStrobe(nvWriteStrobe), .nvWriteValue(nvWriteValue),
    .serClearCmd(serClearCmd), .nvBatchValid(nvBatchValid),
    .nvBatchValue(nvBatchValue));

  task automatic end_of_test;
    if (miscompares == 0 && checksDone > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checksDone++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    bus <= '{addr: a, data: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask : wr

  task automatic rdChk(input logic [7:0] a, input logic [31:0] m, e);
    @(posedge clk);
    bus <= '{addr: a, data: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 chk(rdData & m, e);
  endtask : rdChk

  task automatic waitValve(input logic v);
    for (int n = 0; n < 8 && valveEnable !== v; n++) @(posedge clk) #1;
    chk({31'h0, valveEnable}, {31'h0, v});
    if (valveEnable !== v) end_of_test();
  endtask : waitValve

  task automatic smp(input logic [31:0] v);
    @(posedge clk);
    sampleValid <= 1'b1;
    flowSample <= v;
    @(posedge clk);
    sampleValid <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : smp

  task automatic doReset;
    // Let a pending target save reach the store first
    repeat (2) @(posedge clk);
    rstn <= 1'b0;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    repeat (8) @(posedge clk);
  endtask : doReset

  initial begin
    doReset();
    rdChk(8'h01, 32'hFFFFFFFF, 32'h0);
    rdChk(8'h05, 32'hFFFFFFFF, 32'h0);
    wr(8'h06, 32'h5);
    waitValve(1'b1);
    for (int i = 0; i < 3; i++) smp(32'hA0);
    for (int i = 0; i < 2; i++) smp(32'h8);
    rdChk(8'h01, 32'h7FFFFFF, 32'h1F);
    @(posedge clk) sendClear <= 1'b1;
    @(posedge clk) sendClear <= 1'b0;
    rdChk(8'h01, 32'h7FFFFFF, 32'h0);
    rdChk(8'h03, 32'h3FFFFFF, 32'h0);
    repeat (20) @(posedge clk);
    rdChk(8'h03, 32'hFFF, 32'h2);
    smp(32'h5F5E0FF0);
    rdChk(8'h01, 32'h7FFFFFF, 32'h5F5E0FF);
    smp(32'h20);
    rdChk(8'h01, 32'h7FFFFFF, 32'h1);
    rdChk(8'h02, 32'h1, 32'h1);
    wr(8'h07, 32'h0);
    rdChk(8'h02, 32'h1, 32'h0);
    wr(8'h06, 32'h0);
    waitValve(1'b0);
    wr(8'h5C, 32'h14);
    waitValve(1'b0);
    wr(8'h06, 32'h5);
    waitValve(1'b1);
    smp(32'h50);
    rdChk(8'h04, 32'h7FFFFFF, 32'hF);
    smp(32'h140);
    waitValve(1'b0);
    rdChk(8'h02, 32'h2, 32'h2);
    repeat (30) @(posedge clk);
    @(posedge clk) clearKeyPin <= 1'b1;
    repeat (4) @(posedge clk);
    clearKeyPin <= 1'b0;
    repeat (4) @(posedge clk);
    rdChk(8'h01, 32'h7FFFFFF, 32'h0);
    waitValve(1'b1);
    smp(32'h140);
    waitValve(1'b0);
    wr(8'h5C, 32'h28);
    waitValve(1'b1);
    rdChk(8'h01, 32'h7FFFFFF, 32'h14);
    wr(8'h06, 32'h0);
    waitValve(1'b0);
    wr(8'h5C, 32'h0);
    wr(8'h06, 32'h5);
    waitValve(1'b1);
    smp(32'h500);
    rdChk(8'h01, 32'h7FFFFFF, 32'h64);
    wr(8'h06, 32'h0);
    wr(8'h5C, 32'h28);
    doReset();
    rdChk(8'h5C, 32'h7FFFFFF, 32'h28);
    rdChk(8'h01, 32'h7FFFFFF, 32'h0);
    end_of_test();
  end
endmodule : flow_totalizer_batch_tb

// [ftb_cfg.svh]
/*
  Constants for the flow totalizer and batch block.
  Assumes inclusion by bare name from the top module and its checker.
*/
`ifndef FTB_CFG_SVH
`define FTB_CFG_SVH
`define FTB_CLK_MHZ        250
`define FTB_SEC_NS         1000000000
`define FTB_CLK_NS         4
`define FTB_TICKS_PER_SEC  (`FTB_SEC_NS / `FTB_CLK_NS)
`define FTB_TOTAL_MAX      27'h5F5E0FF
`define FTB_HOURS_MAX      14'h270F
`define FTB_MINSEC_MAX     6'h3B
`define FTB_REG_BATCH      8'h5C
`define FTB_ADDR_TOTAL     8'h01
`define FTB_ADDR_STATUS    8'h02
`define FTB_ADDR_TIME      8'h03
`define FTB_ADDR_REMAIN    8'h04
`define FTB_ADDR_CTRL      8'h05
`define FTB_ADDR_FLOW_TARGET_KEY     8'h06
`define FTB_ADDR_CLEAR     8'h07
`define FTB_ST_OVF_BIT     0
`define FTB_ST_DONE_BIT    1
`define FTB_ST_RUN_BIT     2
`define FTB_ST_VALVE_BIT   3
`define FTB_ST_FROZEN_BIT  4
`endif

// [ftb_flow_totalizer.sv]
/*
  Flow totalizer with overflow policy, elapsed timer and batch stop.
  Assumes a 250 MHz clock, a flow sample strobe from same-domain logic,
  a decoded serial command port, and asynchronous front panel keys.
*/
// Function
// - Accumulate total flow since the last clear.
// - Total holds eight digits; digit weight fixed at build.
// - No-wrap build freezes total at maximum until cleared.
// - Wrap build returns total to zero and keeps counting.
// - Wrap-with-notice build wraps and raises overflow flag.
// - Elapsed timer counts to 9999:59:59.
// - Timer zeroes on clear key, serial clear and power loss.
// - Clear key zeroes total at any time.
// - Serial addressed clear command clears the totalizer.
// - Batch target kept across power loss; total clears at power-up.
// - Serial register 92 writes batch target like the panel.
// - Committed nonzero target starts flow when setpoint nonzero.
// - During a batch show remaining quantity and batch time.
// - At target: valve off, done status, timer paused.
// - Clear after completion zeroes total, new batch starts.
// - Raising target above total resumes flow without clear.
// - Batch runs only with nonzero setpoint; zero cancels.
// - Zero target disables batch; total counts without limit.
`timescale 1ns/10ps
`include "ftb_cfg.svh"
module ftb_flow_totalizer #(
  parameter ftb_pkg::ftb_wrap_t WRAP_MODE  = ftb_pkg::FTB_WRAPNOTE,
  parameter int                 LSD_SHIFT  = 4,
  parameter int                 SAMPLE_W   = 16,
  parameter int                 TICKS_SEC  = `FTB_TICKS_PER_SEC
) (
  input  wire logic                clk,
  input  wire logic                rstn,
  input  wire logic                clearKeyPin,
  input  wire logic                sampleValid,
  input  wire logic [SAMPLE_W-1:0] flowSample,
  input  wire logic                serClearCmd,
  input  wire ftb_pkg::ftb_bus_t   bus,
  input  wire logic                nvBatchValid,
  input  wire logic [26:0]         nvBatchValue,
  output logic [31:0]              rdData,
  output logic                     valveEnable,
  output logic                     overflowFlag,
  output logic                     batchDone,
  output logic [26:0]              totalOut,
  output logic [26:0]              remainOut,
  output ftb_pkg::ftb_time_t       elapsedOut,
  output logic                     nvWriteStrobe,
  output logic [26:0]              nvWriteValue
);

  localparam int ACC_W = 27 + LSD_SHIFT;

  logic                   rstSync1_r;
  logic                   rstSync2_r;
  logic                   keySync1_r;
  logic                   keySync2_r;
  logic                   keyPrev_r;
  logic                   clearPulse;
  logic [ACC_W-1:0]       residue_r;
  logic [26:0]            total_r;
  logic [26:0]            batch_r;
  logic [15:0]            setpoint_r;
  logic                   frozen_r;
  logic [31:0]            secDiv_r;
  ftb_pkg::ftb_time_t     time_r;
  ftb_pkg::ftb_state_t    state_r;
  logic                   tgtCommit;
  logic [ACC_W-1:0]       addSum;
  logic [26:0]            addWhole;
  logic [27:0]            newTotal;
  logic                   timerRun;

  function automatic logic [26:0] ftbSat(input logic [27:0] v);
    ftbSat = (v > 28'(`FTB_TOTAL_MAX)) ? `FTB_TOTAL_MAX : v[26:0];
  endfunction : ftbSat

  // Reset release through two flops
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rstSync1_r <= 1'b0;
      rstSync2_r <= 1'b0;
    end else begin
      rstSync1_r <= 1'b1;
      rstSync2_r <= rstSync1_r;
    end
  end

  // Clear key synchroniser and edge detect
  always_ff @(posedge clk or negedge rstSync2_r) begin
    if (!rstSync2_r) begin
      keySync1_r <= 1'b0;
      keySync2_r <= 1'b0;
      keyPrev_r  <= 1'b0;
    end else begin
      keySync1_r <= clearKeyPin;
      keySync2_r <= keySync1_r;
      keyPrev_r  <= keySync2_r;
    end
  end

  wire logic busClear = bus.wr && (bus.addr == `FTB_ADDR_CLEAR);
  assign clearPulse = (keySync2_r && !keyPrev_r)
                    || serClearCmd || busClear;
  assign tgtCommit  = bus.wr && (bus.addr == `FTB_REG_BATCH);

  // Setpoint from bus writes to the flow target key address only
  always_ff @(posedge clk or negedge rstSync2_r) begin
    if (!rstSync2_r)
      setpoint_r <= 16'h0000;
    else if (bus.wr && bus.addr == `FTB_ADDR_FLOW_TARGET_KEY)
      setpoint_r <= bus.data[15:0];
  end

  // Batch target, reloaded from non-volatile store after power-up
  always_ff @(posedge clk or negedge rstSync2_r) begin
    if (!rstSync2_r)
      batch_r <= 27'h0000000;
    else if (tgtCommit)
      batch_r <= ftbSat({1'b0, bus.data[26:0]});
    else if (nvBatchValid)
      batch_r <= nvBatchValue;
  end

  always_ff @(posedge clk or negedge rstSync2_r) begin
    if (!rstSync2_r) begin
      nvWriteStrobe <= 1'b0;
      nvWriteValue  <= 27'h0000000;
    end else begin
      nvWriteStrobe <= tgtCommit;
      if (tgtCommit)
        nvWriteValue <= ftbSat({1'b0, bus.data[26:0]});
    end
  end

  // Scaled sample plus residue
  assign addSum   = residue_r + ACC_W'(flowSample);
  assign addWhole = 27'(addSum >> LSD_SHIFT);
  assign newTotal = {1'b0, total_r} + {1'b0, addWhole};

  always_ff @(posedge clk or negedge rstSync2_r) begin
    if (!rstSync2_r) begin
      residue_r    <= '0;
      total_r      <= 27'h0000000;
      frozen_r     <= 1'b0;
      overflowFlag <= 1'b0;
    end else if (clearPulse) begin
      residue_r    <= '0;
      total_r      <= 27'h0000000;
      frozen_r     <= 1'b0;
      overflowFlag <= 1'b0;
    end else if (sampleValid && valveEnable && !frozen_r) begin
      residue_r <= addSum & ACC_W'((1 << LSD_SHIFT) - 1);
      if (newTotal > 28'(`FTB_TOTAL_MAX)) begin
        case (WRAP_MODE)
          ftb_pkg::FTB_NOWRAP: begin
            total_r  <= `FTB_TOTAL_MAX;
            frozen_r <= 1'b1;
          end
          ftb_pkg::FTB_WRAP: begin
            total_r <= 27'(newTotal - 28'(`FTB_TOTAL_MAX) - 28'h1);
          end
          default: begin
            total_r      <= 27'(newTotal - 28'(`FTB_TOTAL_MAX) - 28'h1);
            overflowFlag <= 1'b1;
          end
        endcase
      end else begin
        total_r <= newTotal[26:0];
      end
    end
  end

  // Batch sequencing
  always_ff @(posedge clk or negedge rstSync2_r) begin
    if (!rstSync2_r) begin
      state_r <= ftb_pkg::FTB_IDLE;
    end else begin
      case (state_r)
        ftb_pkg::FTB_IDLE: begin
          if (batch_r != 27'h0 && setpoint_r != 16'h0)
            state_r <= ftb_pkg::FTB_RUN;
        end
        ftb_pkg::FTB_RUN: begin
          if (batch_r == 27'h0 || setpoint_r == 16'h0)
            state_r <= ftb_pkg::FTB_IDLE;
          else if (total_r >= batch_r && !clearPulse)
            state_r <= ftb_pkg::FTB_DONE;
        end
        ftb_pkg::FTB_DONE: begin
          if (batch_r == 27'h0)
            state_r <= ftb_pkg::FTB_IDLE;
          else if (clearPulse || batch_r > total_r)
            state_r <= ftb_pkg::FTB_RUN;
        end
        default: state_r <= ftb_pkg::FTB_IDLE;
      endcase
    end
  end

  // Valve gating
  always_ff @(posedge clk or negedge rstSync2_r) begin
    if (!rstSync2_r)
      valveEnable <= 1'b0;
    else if (setpoint_r == 16'h0)
      valveEnable <= 1'b0;
    else if (batch_r == 27'h0)
      valveEnable <= 1'b1;
    else
      valveEnable <= (total_r < batch_r) || clearPulse;
  end

  always_ff @(posedge clk or negedge rstSync2_r) begin
    if (!rstSync2_r)
      batchDone <= 1'b0;
    else
      batchDone <= (state_r == ftb_pkg::FTB_DONE);
  end

  // Elapsed timer, paused once a batch completes
  assign timerRun = (state_r != ftb_pkg::FTB_DONE);

  always_ff @(posedge clk or negedge rstSync2_r) begin
    if (!rstSync2_r) begin
      secDiv_r <= 32'h00000000;
      time_r   <= '0;
    end else if (clearPulse) begin
      secDiv_r <= 32'h00000000;
      time_r   <= '0;
    end else if (timerRun) begin
      if (secDiv_r == 32'(TICKS_SEC - 1)) begin
        secDiv_r <= 32'h00000000;
        if (time_r.seconds != `FTB_MINSEC_MAX) begin
          time_r.seconds <= time_r.seconds + 6'h01;
        end else if (time_r.minutes != `FTB_MINSEC_MAX) begin
          time_r.seconds <= 6'h00;
          time_r.minutes <= time_r.minutes + 6'h01;
        end else if (time_r.hours != `FTB_HOURS_MAX) begin
          time_r.seconds <= 6'h00;
          time_r.minutes <= 6'h00;
          time_r.hours   <= time_r.hours + 14'h0001;
        end
      end else begin
        secDiv_r <= secDiv_r + 32'h00000001;
      end
    end
  end

  // Presented values
  always_ff @(posedge clk or negedge rstSync2_r) begin
    if (!rstSync2_r) begin
      totalOut   <= 27'h0000000;
      remainOut  <= 27'h0000000;
      elapsedOut <= '0;
    end else begin
      totalOut   <= total_r;
      remainOut  <= (total_r >= batch_r) ? 27'h0000000
                                         : batch_r - total_r;
      elapsedOut <= time_r;
    end
  end

  // Register read port, data one cycle after strobe
  always_ff @(posedge clk or negedge rstSync2_r) begin
    if (!rstSync2_r) begin
      rdData <= 32'h00000000;
    end else if (bus.rd) begin
      case (bus.addr)
        `FTB_ADDR_TOTAL:  rdData <= {5'h00, total_r};
        `FTB_REG_BATCH:   rdData <= {5'h00, batch_r};
        `FTB_ADDR_REMAIN: rdData <= {5'h00, remainOut};
        `FTB_ADDR_TIME:   rdData <= {6'h00, time_r};
        `FTB_ADDR_FLOW_TARGET_KEY:  rdData <= {16'h0000, setpoint_r};
        `FTB_ADDR_STATUS: begin
          rdData <= 32'h00000000;
          rdData[`FTB_ST_OVF_BIT]    <= overflowFlag;
          rdData[`FTB_ST_DONE_BIT]   <= batchDone;
          rdData[`FTB_ST_RUN_BIT]    <= (state_r == ftb_pkg::FTB_RUN);
          rdData[`FTB_ST_VALVE_BIT]  <= valveEnable;
          rdData[`FTB_ST_FROZEN_BIT] <= frozen_r;
        end
        default: rdData <= 32'h00000000;
      endcase
    end else begin
      rdData <= 32'h00000000;
    end
  end

endmodule : ftb_flow_totalizer

// [ftb_flow_totalizer_checker.sv]
/*
  Port assertions for the flow totalizer.
  Assumes binding to ftb_flow_totalizer and a single clock domain.
*/
`timescale 1ns/10ps
`include "ftb_cfg.svh"
module ftb_flow_totalizer_checker (
  input wire logic               clk,
  input wire logic               rstn,
  input wire ftb_pkg::ftb_bus_t  bus,
  input wire logic               serClearCmd,
  input wire logic [31:0]        rdData,
  input wire logic               valveEnable,
  input wire logic               overflowFlag,
  input wire logic               batchDone,
  input wire logic [26:0]        totalOut,
  input wire ftb_pkg::ftb_time_t elapsedOut,
  input wire logic               nvWriteStrobe,
  input wire logic [26:0]        nvWriteValue
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence doneHeld;
    batchDone [*3];
  endsequence
  rd_idle_zero_a: assert property (
    !$past(bus.rd) |-> rdData == 32'h0) else $error("stray read data");
  rd_unmapped_a: assert property (
    bus.rd && bus.addr == 8'h05 |=> rdData == 32'h0)
    else $error("unmapped read not zero");
  batch_save_a: assert property (
    bus.wr && bus.addr == `FTB_REG_BATCH |=> nvWriteStrobe
    && nvWriteValue == $past(bus.data[26:0])) else $error("target not saved");
  save_cause_a: assert property (
    nvWriteStrobe |-> $past(bus.wr) && $past(bus.addr) == `FTB_REG_BATCH)
    else $error("save without target write");
  ser_clear_a: assert property (
    serClearCmd |=> !overflowFlag ##1 elapsedOut == 26'h0)
    else $error("serial clear missed timer");
  ser_total_a: assert property (
    serClearCmd |-> ##2 totalOut == 27'h0) else $error("total not cleared");
  done_valve_a: assert property (
    $rose(batchDone) |-> ##[0:1] !valveEnable) else $error("valve open");
  done_pause_a: assert property (
    doneHeld |-> $stable(elapsedOut)) else $error("timer runs when done");
  total_max_a: assert property (
    totalOut <= `FTB_TOTAL_MAX) else $error("total above maximum");
endmodule : ftb_flow_totalizer_checker

bind ftb_flow_totalizer ftb_flow_totalizer_checker u_chk (
  .clk(clk), .rstn(rstn), .bus(bus), .serClearCmd(serClearCmd),
  .rdData(rdData), .valveEnable(valveEnable), .overflowFlag(overflowFlag),
  .batchDone(batchDone), .totalOut(totalOut), .elapsedOut(elapsedOut),
  .nvWriteStrobe(nvWriteStrobe), .nvWriteValue(nvWriteValue));

// [ftb_host_model.sv]
/*
  Host serial clear and nonvolatile target store.
  Assumes the same clock as the totalizer.
*/
`timescale 1ns/10ps
module ftb_host_model (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        sendClear,
  input  wire logic        nvWriteStrobe,
  input  wire logic [26:0] nvWriteValue,
  output logic             serClearCmd,
  output logic             nvBatchValid,
  output logic [26:0]      nvBatchValue
);
  logic [26:0] store_r = 27'h0;
  logic [2:0]  bootCnt_r;
  // Decoded address, clear command, return
  always @(posedge clk) serClearCmd <= sendClear;
  // Store survives reset
  always @(posedge clk) if (nvWriteStrobe) store_r <= nvWriteValue;
  always @(posedge clk or negedge rstn) begin
    if (!rstn) bootCnt_r <= 3'h0;
    else if (bootCnt_r != 3'h7) bootCnt_r <= bootCnt_r + 3'h1;
  end
  assign nvBatchValid = (bootCnt_r == 3'h6);
  assign nvBatchValue = store_r;
endmodule : ftb_host_model

// [ftb_pkg.sv]
/*
  Types for the flow totalizer and batch block.
  Assumes ftb_cfg.svh holds all numeric constants.
*/
package ftb_pkg;
  typedef enum logic [1:0] {
    FTB_NOWRAP,
    FTB_WRAP,
    FTB_WRAPNOTE
  } ftb_wrap_t;

  typedef enum logic [1:0] {
    FTB_IDLE,
    FTB_RUN,
    FTB_DONE
  } ftb_state_t;

  typedef struct packed {
    logic [13:0] hours;
    logic [5:0]  minutes;
    logic [5:0]  seconds;
  } ftb_time_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] data;
    logic        wr;
    logic        rd;
  } ftb_bus_t;
endpackage : ftb_pkg
